// *** rcg_pkg.sv ***
`default_nettype none

package rcg_pkg;

   // **********************************************************
   // register map
   // **********************************************************
   localparam int           ADDR_W        = 12;
   localparam logic [11:0]  OFS_CTRL      = 12'h000;
   localparam logic [11:0]  OFS_TRIM      = 12'h004;
   localparam logic [31:0]  CTRL_RST      = 32'h0000_0000;
   localparam logic [31:0]  TRIM_RST      = 32'h0000_0000;
   localparam logic [31:0]  CTRL_WMASK    = 32'h7fff_ba0f;
   localparam logic [31:0]  TRIM_WMASK    = 32'hff80_0000;

   // **********************************************************
   // control register fields
   // **********************************************************
   localparam int           DIV_LSB       = 16;
   localparam int           DIV_W         = 15;
   localparam int           ON_BIT        = 15;
   localparam int           STOP_IN_IDLE_BIT      = 13;
   localparam int           OE_BIT        = 12;
   localparam int           RUN_IN_SLEEP_BIT      = 11;
   localparam int           DIVSW_BIT     = 9;
   localparam int           ACTIVE_BIT    = 8;
   localparam int           SEL_LSB       = 0;
   localparam int           SEL_W         = 4;

   // **********************************************************
   // trim register fields
   // **********************************************************
   localparam int           TRIM_LSB      = 23;
   localparam int           TRIM_W        = 9;

   // **********************************************************
   // source codes
   // **********************************************************
   localparam int           NUM_SRC       = 9;
   localparam logic [3:0]   SRC_SYSTEM_CLOCK    = 4'h0;
   localparam logic [3:0]   SRC_PERIPHERAL_BUS_CLOCK     = 4'h1;
   localparam logic [3:0]   SRC_LAST      = 4'h8;

   // **********************************************************
   // bus responses
   // **********************************************************
   localparam logic [1:0]   RESP_OKAY     = 2'h0;
   localparam logic [1:0]   RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic [SEL_W-1:0]  sel;
      logic [DIV_W-1:0]  div;
      logic [TRIM_W-1:0] trim;
   } rcg_cfg_type;

   localparam rcg_cfg_type CFG_RST = '{sel: 4'h0, div: 15'h0000, trim: 9'h000};

endpackage

`default_nettype wire

// *** rcg_div.sv ***
`timescale 1ns/1ps
`default_nettype none

module rcg_div (
   input  wire logic                mclk_in,   // core clock
   input  wire logic                rst_in,    // sync reset, high
   input  wire logic                src_in,    // synchronised source level
   input  wire logic                run_in,    // divider allowed to run
   input  wire rcg_pkg::rcg_cfg_type cfg_in,   // settings in effect
   output logic                     clk_out,   // divided clock level
   output logic                     bound_out  // pulse at each half-period edge, or at each source rise when div is 0
);

   logic                       src_prev_r;
   logic [rcg_pkg::DIV_W-1:0]  cnt_r;
   logic [rcg_pkg::TRIM_W-1:0] acc_r;
   logic                       clk_r;
   logic                       bound_r;
   logic                       rise;
   logic [rcg_pkg::TRIM_W:0]   acc_sum;
   logic [rcg_pkg::DIV_W:0]    half_len;
   logic [rcg_pkg::DIV_W:0]    cnt_inc;

   assign rise     = src_in & ~src_prev_r;
   assign acc_sum  = {1'b0, acc_r} + {1'b0, cfg_in.trim};
   // fractional carry stretches this half period by one source edge
   assign half_len = {1'b0, cfg_in.div} + {15'h0000, acc_sum[rcg_pkg::TRIM_W]};
   assign cnt_inc  = {1'b0, cnt_r} + 16'h0001;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         src_prev_r <= 1'b0;
      end else begin
         src_prev_r <= src_in;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in || !run_in) begin
         cnt_r   <= '0;
         acc_r   <= '0;
         clk_r   <= 1'b0;
         bound_r <= 1'b0;
      end else if (cfg_in.div == '0) begin
         clk_r   <= src_in;
         bound_r <= rise;
         cnt_r   <= '0;
      end else if (rise) begin
         if (cnt_inc >= half_len) begin
            cnt_r   <= '0;
            acc_r   <= acc_sum[rcg_pkg::TRIM_W-1:0];
            clk_r   <= ~clk_r;
            bound_r <= 1'b1;
         end else begin
            cnt_r   <= cnt_inc[rcg_pkg::DIV_W-1:0];
            bound_r <= 1'b0;
         end
      end else begin
         bound_r <= 1'b0;
      end
   end

   assign clk_out   = clk_r;
   assign bound_out = bound_r;

endmodule

`default_nettype wire

// *** rcg_top.sv ***
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module rcg_top (
   input  wire logic                       mclk_in,          // core clock, 250 MHz
   input  wire logic                       rst_in,           // sync reset, high
   // axi4-lite slave
   input  wire logic [rcg_pkg::ADDR_W-1:0] s_axi_awaddr_in,  // write address
   input  wire logic                       s_axi_awvalid_in, // write address valid
   output logic                            s_axi_awready_out,// write address ready
   input  wire logic [31:0]                s_axi_wdata_in,   // write data
   input  wire logic [3:0]                 s_axi_wstrb_in,   // write byte strobes
   input  wire logic                       s_axi_wvalid_in,  // write data valid
   output logic                            s_axi_wready_out, // write data ready
   output logic [1:0]                      s_axi_bresp_out,  // write response
   output logic                            s_axi_bvalid_out, // write response valid
   input  wire logic                       s_axi_bready_in,  // write response ready
   input  wire logic [rcg_pkg::ADDR_W-1:0] s_axi_araddr_in,  // read address
   input  wire logic                       s_axi_arvalid_in, // read address valid
   output logic                            s_axi_arready_out,// read address ready
   output logic [31:0]                     s_axi_rdata_out,  // read data
   output logic [1:0]                      s_axi_rresp_out,  // read response
   output logic                            s_axi_rvalid_out, // read data valid
   input  wire logic                       s_axi_rready_in,  // read data ready
   // device power state
   input  wire logic                       idle_mode_in,     // device in Idle
   input  wire logic                       sleep_mode_in,    // device in Sleep
   // clock sources, index = source code
   input  wire logic [8:0]                 src_clk_in,       // raw source levels
   // outputs
   output logic                            ref_clock_out,            // internal reference clock
   output logic                            ref_clock_out_pin_out,    // pin level
   output logic                            ref_clock_out_pin_oe_out  // pin drive enable
);

   // **********************************************************
   // declarations
   // **********************************************************
   typedef enum logic [0:0] {SW_IDLE, SW_WAIT} rcg_sw_type;

   rcg_sw_type                sw_state_r;
   logic [rcg_pkg::NUM_SRC-1:0] sync1_r;
   logic [rcg_pkg::NUM_SRC-1:0] sync2_r;

   logic                      on_r;
   logic                      stop_in_idle_r;
   logic                      oe_r;
   logic                      run_in_sleep_r;
   logic                      divsw_r;
   logic                      run_r;
   rcg_pkg::rcg_cfg_type      pend_cfg_r;
   rcg_pkg::rcg_cfg_type      act_cfg_r;

   logic                      aw_held_r;
   logic [rcg_pkg::ADDR_W-1:0] awaddr_r;
   logic                      w_held_r;
   logic [31:0]               wdata_r;
   logic [3:0]                wstrb_r;
   logic                      awready_r;
   logic                      wready_r;
   logic                      bvalid_r;
   logic [1:0]                bresp_r;
   logic                      arready_r;
   logic                      rvalid_r;
   logic [31:0]               rdata_r;
   logic [1:0]                rresp_r;

   logic                      pin_r;
   logic                      pin_oe_r;
   logic                      ref_clk_r;

   logic                      aw_take;
   logic                      w_take;
   logic                      ar_take;
   logic                      do_write;
   logic                      wr_ctrl;
   logic                      wr_trim;
   logic [31:0]               byte_mask;
   logic [31:0]               ctrl_rd;
   logic [31:0]               trim_rd;
   logic [31:0]               ctrl_new;
   logic [31:0]               trim_new;
   logic                      divsw_set;
   logic                      sw_done;
   logic                      sleep_block;
   logic                      run_nxt;
   logic                      src_sel;
   logic                      div_clk;
   logic                      div_bound;
   rcg_pkg::rcg_cfg_type      pend_cfg_nxt;

   // **********************************************************
   // source synchroniser and selection
   // **********************************************************
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= src_clk_in;
         sync2_r <= sync1_r;
      end
   end

   // reserved codes select nothing; the output then stops toggling
   always_comb begin
      if (act_cfg_r.sel <= rcg_pkg::SRC_LAST) begin
         src_sel = sync2_r[act_cfg_r.sel];
      end else begin
         src_sel = 1'b0;
      end
   end

   // **********************************************************
   // bus handshakes
   // **********************************************************
   assign aw_take  = s_axi_awvalid_in & awready_r;
   assign w_take   = s_axi_wvalid_in & wready_r;
   assign ar_take  = s_axi_arvalid_in & arready_r;
   assign do_write = aw_held_r & w_held_r & ~bvalid_r;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         aw_held_r <= 1'b0;
         awaddr_r  <= '0;
      end else if (aw_take) begin
         aw_held_r <= 1'b1;
         awaddr_r  <= s_axi_awaddr_in;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         w_held_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else if (w_take) begin
         w_held_r <= 1'b1;
         wdata_r  <= s_axi_wdata_in;
         wstrb_r  <= s_axi_wstrb_in;
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end
   end

   // ready drops as soon as a beat is held, so a second beat cannot overrun it
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
      end else begin
         awready_r <= ~(aw_take | (aw_held_r & ~do_write));
         wready_r  <= ~(w_take | (w_held_r & ~do_write));
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         bvalid_r <= 1'b0;
         bresp_r  <= rcg_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r  <= (wr_ctrl | wr_trim) ? rcg_pkg::RESP_OKAY : rcg_pkg::RESP_SLVERR;
      end else if (s_axi_bready_in) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         arready_r <= 1'b0;
      end else begin
         arready_r <= ~(ar_take | (rvalid_r & ~s_axi_rready_in));
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= rcg_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         if (s_axi_araddr_in == rcg_pkg::OFS_CTRL) begin
            rdata_r <= ctrl_rd;
            rresp_r <= rcg_pkg::RESP_OKAY;
         end else if (s_axi_araddr_in == rcg_pkg::OFS_TRIM) begin
            rdata_r <= trim_rd;
            rresp_r <= rcg_pkg::RESP_OKAY;
         end else begin
            rdata_r <= '0;
            rresp_r <= rcg_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rready_in) begin
         rvalid_r <= 1'b0;
      end
   end

   // **********************************************************
   // register images and write merge
   // **********************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign byte_mask[8*gi +: 8] = {8{wstrb_r[gi]}};
      end
   endgenerate

   always_comb begin
      ctrl_rd = '0;
      ctrl_rd[rcg_pkg::DIV_LSB +: rcg_pkg::DIV_W] = pend_cfg_r.div;
      ctrl_rd[rcg_pkg::ON_BIT]     = on_r;
      ctrl_rd[rcg_pkg::STOP_IN_IDLE_BIT]   = stop_in_idle_r;
      ctrl_rd[rcg_pkg::OE_BIT]     = oe_r;
      ctrl_rd[rcg_pkg::RUN_IN_SLEEP_BIT]   = run_in_sleep_r;
      ctrl_rd[rcg_pkg::DIVSW_BIT]  = divsw_r;
      ctrl_rd[rcg_pkg::ACTIVE_BIT] = run_r;
      ctrl_rd[rcg_pkg::SEL_LSB +: rcg_pkg::SEL_W] = pend_cfg_r.sel;
   end

   always_comb begin
      trim_rd = '0;
      trim_rd[rcg_pkg::TRIM_LSB +: rcg_pkg::TRIM_W] = pend_cfg_r.trim;
   end

   assign wr_ctrl  = do_write & (awaddr_r == rcg_pkg::OFS_CTRL);
   assign wr_trim  = do_write & (awaddr_r == rcg_pkg::OFS_TRIM);
   // only implemented bits take the write
   assign ctrl_new = (ctrl_rd & ~(byte_mask & rcg_pkg::CTRL_WMASK))
                   | (wdata_r & byte_mask & rcg_pkg::CTRL_WMASK);
   assign trim_new = (trim_rd & ~(byte_mask & rcg_pkg::TRIM_WMASK))
                   | (wdata_r & byte_mask & rcg_pkg::TRIM_WMASK);
   assign divsw_set = wr_ctrl & ctrl_new[rcg_pkg::DIVSW_BIT];

   always_comb begin
      pend_cfg_nxt = pend_cfg_r;
      if (wr_ctrl) begin
         pend_cfg_nxt.div = ctrl_new[rcg_pkg::DIV_LSB +: rcg_pkg::DIV_W];
         pend_cfg_nxt.sel = ctrl_new[rcg_pkg::SEL_LSB +: rcg_pkg::SEL_W];
      end
      if (wr_trim) begin
         pend_cfg_nxt.trim = trim_new[rcg_pkg::TRIM_LSB +: rcg_pkg::TRIM_W];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         on_r   <= rcg_pkg::CTRL_RST[rcg_pkg::ON_BIT];
         stop_in_idle_r <= rcg_pkg::CTRL_RST[rcg_pkg::STOP_IN_IDLE_BIT];
         oe_r   <= rcg_pkg::CTRL_RST[rcg_pkg::OE_BIT];
         run_in_sleep_r <= rcg_pkg::CTRL_RST[rcg_pkg::RUN_IN_SLEEP_BIT];
      end else if (wr_ctrl) begin
         on_r   <= ctrl_new[rcg_pkg::ON_BIT];
         stop_in_idle_r <= ctrl_new[rcg_pkg::STOP_IN_IDLE_BIT];
         oe_r   <= ctrl_new[rcg_pkg::OE_BIT];
         run_in_sleep_r <= ctrl_new[rcg_pkg::RUN_IN_SLEEP_BIT];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         pend_cfg_r <= rcg_pkg::CFG_RST;
      end else begin
         pend_cfg_r <= pend_cfg_nxt;
      end
   end

   // **********************************************************
   // divider switch handshake
   // **********************************************************
   // switch waits for a half-period edge while running, so the output never glitches, and completes at once when halted
   assign sw_done = (sw_state_r == SW_WAIT) & (~run_r | div_bound);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         sw_state_r <= SW_IDLE;
      end else begin
         unique case (sw_state_r)
            SW_IDLE: begin
               if (divsw_r) begin
                  sw_state_r <= SW_WAIT;
               end
            end
            SW_WAIT: begin
               if (sw_done) begin
                  sw_state_r <= SW_IDLE;
               end
            end
         endcase
      end
   end

   // a software set in the completion cycle wins over the hardware clear
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         divsw_r <= rcg_pkg::CTRL_RST[rcg_pkg::DIVSW_BIT];
      end else if (divsw_set) begin
         divsw_r <= 1'b1;
      end else if (sw_done) begin
         divsw_r <= 1'b0;
      end
   end

   // disabled: settings follow the register; enabled: only on a switch
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         act_cfg_r <= rcg_pkg::CFG_RST;
      end else if (!on_r || sw_done) begin
         // a write that also sets the enable bit still lands while disabled
         act_cfg_r <= on_r ? pend_cfg_r : pend_cfg_nxt;
      end
   end

   // **********************************************************
   // run control
   // **********************************************************
   // system and bus clocks stop in sleep anyway, so run-in-sleep is moot there
   assign sleep_block = sleep_mode_in
                      & ~(run_in_sleep_r & (act_cfg_r.sel != rcg_pkg::SRC_SYSTEM_CLOCK)
                                 & (act_cfg_r.sel != rcg_pkg::SRC_PERIPHERAL_BUS_CLOCK));
   assign run_nxt     = on_r
                      & ~(idle_mode_in & stop_in_idle_r)
                      & ~sleep_block;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         run_r <= 1'b0;
      end else begin
         run_r <= run_nxt;
      end
   end

   // **********************************************************
   // divider and outputs
   // **********************************************************
   rcg_div rcg_div_inst (
      .mclk_in   (mclk_in),
      .rst_in    (rst_in),
      .src_in    (src_sel),
      .run_in    (run_r),
      .cfg_in    (act_cfg_r),
      .clk_out   (div_clk),
      .bound_out (div_bound)
   );

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         ref_clk_r <= 1'b0;
         pin_r     <= 1'b0;
         pin_oe_r  <= 1'b0;
      end else begin
         ref_clk_r <= div_clk;
         pin_r     <= div_clk & oe_r;
         pin_oe_r  <= oe_r;
      end
   end

   assign ref_clock_out            = ref_clk_r;
   assign ref_clock_out_pin_out    = pin_r;
   assign ref_clock_out_pin_oe_out = pin_oe_r;

   assign s_axi_awready_out = awready_r;
   assign s_axi_wready_out  = wready_r;
   assign s_axi_bvalid_out  = bvalid_r;
   assign s_axi_bresp_out   = bresp_r;
   assign s_axi_arready_out = arready_r;
   assign s_axi_rvalid_out  = rvalid_r;
   assign s_axi_rdata_out   = rdata_r;
   assign s_axi_rresp_out   = rresp_r;

endmodule

`default_nettype wire

// *** rcg_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none

module rcg_top_props (
   input wire logic                       mclk_in,                 // clock
   input wire logic                       rst_in,                  // reset
   input wire logic [rcg_pkg::ADDR_W-1:0] s_axi_awaddr_in,         // aw
   input wire logic                       s_axi_awvalid_in,        // aw
   input wire logic                       s_axi_awready_out,       // aw
   input wire logic [31:0]                s_axi_wdata_in,          // w
   input wire logic                       s_axi_wvalid_in,         // w
   input wire logic                       s_axi_wready_out,        // w
   input wire logic                       s_axi_bvalid_out,        // b
   input wire logic                       s_axi_arvalid_in,        // ar
   input wire logic                       s_axi_arready_out,       // ar
   input wire logic                       s_axi_rvalid_out,        // r
   input wire logic                       idle_mode_in,            // idle
   input wire logic                       sleep_mode_in,           // sleep
   input wire logic                       ref_clock_out,           // clock out
   input wire logic                       ref_clock_out_pin_out,   // pin
   input wire logic                       ref_clock_out_pin_oe_out // pin enable
);
   // ****************************************
   // mirror of software control writes
   // ****************************************
   // mirror leads the design by a few cycles, hence the long repetitions below
   logic [31:0] ctl_r;
   logic [3:0]  oe_r;
   wire         wtake = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         ctl_r <= '0;
         oe_r  <= '0;
      end else begin
         if (wtake && s_axi_awaddr_in == rcg_pkg::OFS_CTRL) ctl_r <= s_axi_wdata_in;
         oe_r <= {oe_r[2:0], ctl_r[rcg_pkg::OE_BIT]};
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   sequence s_off; !ctl_r[rcg_pkg::ON_BIT] [*6]; endsequence
   sequence s_idle; (idle_mode_in && ctl_r[rcg_pkg::STOP_IN_IDLE_BIT]) [*6]; endsequence
   sequence s_slp; (sleep_mode_in && !ctl_r[rcg_pkg::RUN_IN_SLEEP_BIT]) [*6]; endsequence
   sequence s_slsys; (sleep_mode_in && ctl_r[3:0] <= 4'h1) [*6]; endsequence

   a_off_quiet: assert property (s_off |-> !ref_clock_out)
      else $error("clock runs while disabled");
   a_idle_halt: assert property (s_idle |-> !ref_clock_out)
      else $error("clock runs in idle");
   a_sleep_stop: assert property (s_slp |-> !ref_clock_out)
      else $error("clock runs in sleep");
   a_sleep_sys: assert property (s_slsys |-> !ref_clock_out)
      else $error("bus clock source runs in sleep");
   a_pin_gate: assert property (ref_clock_out_pin_out |-> ref_clock_out_pin_oe_out)
      else $error("pin toggles without enable");
   a_oe_follows: assert property ((&oe_r[3:1] || !(|oe_r[3:1]))
      |-> ref_clock_out_pin_oe_out == oe_r[2])
      else $error("pin enable not following control");
   a_write_answer: assert property (wtake |-> ##[2:3] s_axi_bvalid_out)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |-> ##[1:2] s_axi_rvalid_out)
      else $error("read response late");
endmodule

bind rcg_top rcg_top_props rcg_top_props_inst (.*);

`default_nettype wire

// *** rcg_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin fails++; \
   $display("CHECK FAILED %s exp %h seen %h", n, e, s); end end

module rcg_top_test;
   logic        mclk_in = '0, rst_in = '1, s_axi_awvalid_in = '0, s_axi_wvalid_in = '0;
   logic        s_axi_bready_in = '0, s_axi_arvalid_in = '0, s_axi_rready_in = '0;
   logic        idle_mode_in = '0, sleep_mode_in = '0, ref_clock_out, ref_clock_out_pin_out;
   logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   logic        s_axi_rvalid_out, ref_clock_out_pin_oe_out;
   logic [11:0] s_axi_awaddr_in = '0, s_axi_araddr_in = '0;
   logic [31:0] s_axi_wdata_in = '0, s_axi_rdata_out, rd, seed = 32'ha99d9d68;
   logic [3:0]  s_axi_wstrb_in = 4'hf;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rs;
   logic [8:0]  src_clk_in = '0;
   logic [4:0]  sc = '0;
   int          fails = 0, n_tests = 0, cyc = 0, r, p;

   rcg_top rcg_top_inst (.*);

   always #2 mclk_in = ~mclk_in;

   // sources of period 4, 8 and 16 cycles, slow enough for the two-flop sync
   always @(posedge mclk_in) begin
      sc <= sc + 5'h1;
      src_clk_in <= {3{sc[3:1]}};
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         print_verdict();
      end
   end

   function automatic logic [31:0] nx(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic int ex(int d, int t, int per, int w);
      return (d == 0) ? w / per : (w * 512) / (2 * per * (d * 512 + t));
   endfunction
   // flags are {enable, stop_in_idle, pin enable, run_in_sleep}
   function automatic logic [31:0] cw(logic [3:0] f, logic [3:0] sel, logic [14:0] d);
      return {1'h0, d, f[3], 1'h0, f[2:0], 7'h0, sel};
   endfunction

   task automatic wr(logic [11:0] a, logic [31:0] d);
      @(posedge mclk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'h1;
      s_axi_wvalid_in <= 1'h1;
      s_axi_bready_in <= 1'h1;
      do begin
         @(posedge mclk_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
      end while (s_axi_bvalid_out !== 1'h1);
      rs = s_axi_bresp_out;
      s_axi_bready_in <= 1'h0;
   endtask

   task automatic rdr(logic [11:0] a);
      @(posedge mclk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'h1;
      s_axi_rready_in <= 1'h1;
      do begin
         @(posedge mclk_in);
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
      end while (s_axi_rvalid_out !== 1'h1);
      rd = s_axi_rdata_out;
      rs = s_axi_rresp_out;
      s_axi_rready_in <= 1'h0;
   endtask

   // clears only the enable byte, so source and divider stay as they are
   task automatic off();
      s_axi_wstrb_in <= 4'h2;
      wr(rcg_pkg::OFS_CTRL, 32'h0);
      s_axi_wstrb_in <= 4'hf;
   endtask

   // rising edges counted over a window; one edge of slack for phase
   task automatic rate(int e, int w);
      logic a = ref_clock_out;
      logic b = ref_clock_out_pin_out;
      r = 0;
      p = 0;
      repeat (w) begin
         @(posedge mclk_in);
         r += int'(ref_clock_out === 1'h1 && a === 1'h0);
         p += int'(ref_clock_out_pin_out === 1'h1 && b === 1'h0);
         a = ref_clock_out;
         b = ref_clock_out_pin_out;
      end
      `CHK("rate", 1'h1, (r - e <= 1) && (e - r <= 1))
   endtask

   task print_verdict;
      $display("checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'h0;
      rdr(rcg_pkg::OFS_CTRL);
      `CHK("ctrl_rst", rcg_pkg::CTRL_RST, rd)
      rdr(rcg_pkg::OFS_TRIM);
      `CHK("trim_rst", rcg_pkg::TRIM_RST, rd)
      rdr(12'h008);
      `CHK("rd_bad", {rcg_pkg::RESP_SLVERR, 32'h0}, {rs, rd})
      wr(12'h008, seed);
      `CHK("wr_bad", rcg_pkg::RESP_SLVERR, rs)
      rate(0, 200);
      wr(rcg_pkg::OFS_CTRL, 32'hffff_7d70);
      rdr(rcg_pkg::OFS_CTRL);
      `CHK("ctrl_mask", 32'hffff_7d70 & rcg_pkg::CTRL_WMASK & ~32'h200, rd)
      wr(rcg_pkg::OFS_TRIM, 32'hffff_ffff);
      rdr(rcg_pkg::OFS_TRIM);
      `CHK("trim_mask", rcg_pkg::TRIM_WMASK, rd)
      $display("test map done");
      for (int k = 0; k < rcg_pkg::NUM_SRC; k++) begin
         int d, t;
         seed = nx(seed);
         d = seed[1:0];
         t = seed[10:2];
         off();
         wr(rcg_pkg::OFS_CTRL, cw(4'h0, k[3:0], d[14:0]));
         wr(rcg_pkg::OFS_TRIM, {t[8:0], 23'h0});
         wr(rcg_pkg::OFS_CTRL, cw({2'h2, k[0], 1'h0}, k[3:0], d[14:0]));
         rdr(rcg_pkg::OFS_CTRL);
         `CHK("active", 1'h1, rd[rcg_pkg::ACTIVE_BIT])
         repeat (20) @(posedge mclk_in);
         rate(ex(d, t, 4 << (k % 3), 1024), 1024);
         `CHK("pin", 1'h1, k[0] ? (p - r <= 1 && r - p <= 1) : p == 0)
         `CHK("oe", k[0], ref_clock_out_pin_oe_out)
      end
      $display("test sources done");
      off();
      wr(rcg_pkg::OFS_CTRL, cw(4'h0, 4'h2, 15'h7));
      wr(rcg_pkg::OFS_TRIM, 32'h0);
      wr(rcg_pkg::OFS_CTRL, cw(4'hc, 4'h2, 15'h7));
      seed = nx(seed);
      wr(rcg_pkg::OFS_TRIM, {seed[8:0], 23'h0});
      // halted in idle, so the request bit is low while the divider is rewritten
      idle_mode_in <= 1'h1;
      wr(rcg_pkg::OFS_CTRL, cw(4'hc, 4'h2, 15'h1));
      idle_mode_in <= 1'h0;
      repeat (20) @(posedge mclk_in);
      rate(ex(7, 0, 16, 1024), 1024);
      wr(rcg_pkg::OFS_CTRL, cw(4'hc, 4'h2, 15'h1) | 32'h200);
      rdr(rcg_pkg::OFS_CTRL);
      `CHK("sw_busy", 1'h1, rd[rcg_pkg::DIVSW_BIT])
      for (int i = 0; i < 60 && rd[rcg_pkg::DIVSW_BIT]; i++) rdr(rcg_pkg::OFS_CTRL);
      `CHK("sw_done", 1'h0, rd[rcg_pkg::DIVSW_BIT])
      repeat (20) @(posedge mclk_in);
      rate(ex(1, seed[8:0], 16, 1024), 1024);
      $display("test switch done");
      for (int i = 0; i < 32; i++) begin
         logic [3:0] sl;
         logic       run;
         sl = i[4] ? 4'h1 : 4'h3;
         off();
         idle_mode_in <= i[2];
         sleep_mode_in <= i[3];
         wr(rcg_pkg::OFS_CTRL, cw({1'h1, i[0], 1'h0, i[1]}, sl, 15'h1));
         run = !(i[2] && i[0]) && !(i[3] && !(i[1] && !i[4]));
         rdr(rcg_pkg::OFS_CTRL);
         `CHK("req", run, rd[rcg_pkg::ACTIVE_BIT])
         repeat (8) @(posedge mclk_in);
         rate(run ? ex(1, seed[8:0], i[4] ? 8 : 4, 256) : 0, 256);
      end
      $display("test power done");
      print_verdict();
   end
endmodule

`default_nettype wire
